/* burst_resolution_pkg.sv */
package burst_resolution_pkg;

   // ----------------------------------------------------------------
   // Register map of one serial pair page
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_BURST_CONTROL = 8'h37;
   localparam logic [7:0] ADDR_LOW_RES_COUNT_TOP = 8'h39;
   localparam logic [7:0] ADDR_LOW_RES_COUNT_UPPER = 8'h3A;
   localparam logic [7:0] ADDR_LOW_RES_COUNT_MIDDLE = 8'h3B;
   localparam logic [7:0] ADDR_LOW_RES_COUNT_BOTTOM = 8'h3C;
   localparam logic [7:0] ADDR_HIGH_RES_COUNT_TOP = 8'h3D;
   localparam logic [7:0] ADDR_HIGH_RES_COUNT_UPPER = 8'h3E;
   localparam logic [7:0] ADDR_HIGH_RES_COUNT_MIDDLE = 8'h3F;
   localparam logic [7:0] ADDR_HIGH_RES_COUNT_BOTTOM = 8'h40;

   // ----------------------------------------------------------------
   // Field positions of the burst control register
   // ----------------------------------------------------------------
   localparam int SECOND_BIT_FLAG_EN_POS = 7;
   localparam int FIRST_BIT_FLAG_EN_POS = 6;
   localparam int LOAD_COUNTS_POS = 5;
   localparam int TRIGGER_CROSS_POS = 4;
   localparam int AUTO_TRIGGER_POS = 3;
   localparam int RATIO_INVALID_POS = 1;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hF8;
   localparam logic [7:0] TOP_NIBBLE_MASK = 8'h0F;

   // ----------------------------------------------------------------
   // Sizes and values after reset
   // ----------------------------------------------------------------
   localparam int COUNT_WIDTH = 28;
   localparam int PAIR_COUNT = 2;
   localparam logic [29:0] MIN_RATIO = 30'h0000_0003;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [27:0] COUNT_RESET = 28'h000_0000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } reg_rsp_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_HIGH,
      SEQ_LOW
   } seq_state_t;

endpackage

/* burst_sequencer.sv */
`timescale 1ns/1ps
module burst_sequencer
   import burst_resolution_pkg::*;
#(
   parameter int CW = COUNT_WIDTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Burst request and lengths
   input wire logic trigger_i,
   input wire logic [CW-1:0] high_len_i,
   input wire logic [CW-1:0] low_len_i,
   // Burst status
   output logic high_res_flag_o,
   output logic busy_o
);

   typedef struct packed {
      seq_state_t state;
      logic [CW-1:0] remain;
      logic flag;
   } seq_t;

   seq_t cur;
   seq_t next_cur;

   // ----------------------------------------------------------------
   // Burst walk
   // ----------------------------------------------------------------
   // A trigger during a burst is dropped, so a burst always completes.
   always_comb begin
      next_cur = cur;
      unique case (cur.state)
         SEQ_IDLE: begin
            if (trigger_i && high_len_i != '0) begin
               next_cur.state = SEQ_HIGH;
               next_cur.remain = high_len_i - CW'(1);
               next_cur.flag = 1'b1;
            end else if (trigger_i && low_len_i != '0) begin
               next_cur.state = SEQ_LOW;
               next_cur.remain = low_len_i - CW'(1);
               next_cur.flag = 1'b0;
            end
         end
         SEQ_HIGH: begin
            if (cur.remain != '0) begin
               next_cur.remain = cur.remain - CW'(1);
            end else if (low_len_i != '0) begin
               next_cur.state = SEQ_LOW;
               next_cur.remain = low_len_i - CW'(1);
               next_cur.flag = 1'b0;
            end else begin
               next_cur.state = SEQ_IDLE;
               next_cur.flag = 1'b0;
            end
         end
         SEQ_LOW: begin
            if (cur.remain != '0) begin
               next_cur.remain = cur.remain - CW'(1);
            end else begin
               next_cur.state = SEQ_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur <= '{state: SEQ_IDLE, remain: '0, flag: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   assign high_res_flag_o = cur.flag;
   assign busy_o = (cur.state != SEQ_IDLE);

   a_burst_flag_start:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cur.state == SEQ_IDLE && trigger_i && high_len_i != '0)
         |=> high_res_flag_o && busy_o)
   else $error("High-resolution flag did not start the burst.");

endmodule

/* burst_resolution_control.sv */
`timescale 1ns/1ps
module burst_resolution_control
   import burst_resolution_pkg::*;
#(
   parameter int CW = COUNT_WIDTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Paged register port
   input wire reg_req_t reg_req_i,
   output reg_rsp_t reg_rsp_o,
   // Trigger pins, first pair then second pair
   input wire logic first_pair_trigger_pin_i,
   input wire logic second_pair_trigger_pin_i,
   // Low-resolution sample counts offered to each page
   input wire logic [PAIR_COUNT-1:0][CW-1:0] low_res_count_i,
   // Output LSBs per pair, bit 1 above bit 0
   output logic [PAIR_COUNT-1:0][1:0] res_lsb_o,
   output logic [PAIR_COUNT-1:0] burst_busy_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PAIR_COUNT-1:0][7:0] control;
      logic [PAIR_COUNT-1:0][CW-1:0] high_stage;
      logic [PAIR_COUNT-1:0][CW-1:0] high_active;
      logic [PAIR_COUNT-1:0][CW-1:0] low_active;
      logic [PAIR_COUNT-1:0] pin_prev;
      logic [PAIR_COUNT-1:0][1:0] lsb;
      reg_rsp_t rsp;
   } ctl_t;

   ctl_t cur;
   ctl_t next_cur;
   logic [PAIR_COUNT-1:0] pin_now;
   logic [PAIR_COUNT-1:0] trigger;
   logic [PAIR_COUNT-1:0] ratio_invalid;
   logic [PAIR_COUNT-1:0] flag;
   logic [PAIR_COUNT-1:0] busy;

   assign pin_now = {second_pair_trigger_pin_i, first_pair_trigger_pin_i};

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // The low count must be at least three times the high count.
   function automatic logic ratio_bad(input logic [CW-1:0] low, input logic [CW-1:0] high);
      logic [29:0] low_w;
      logic [29:0] triple;
      low_w = 30'(low);
      triple = 30'(high) * MIN_RATIO;
      return low_w < triple;
   endfunction

   // Top byte holds only bits 27 to 24, the rest read as zero.
   function automatic logic [7:0] count_byte(input logic [CW-1:0] count, input int idx);
      logic [31:0] wide;
      wide = 32'(count);
      return wide[idx*8 +: 8];
   endfunction

   function automatic logic [7:0] read_mux(input ctl_t s, input logic pg,
                                            input logic [7:0] addr, input logic alarm);
      logic [7:0] d;
      d = 8'h00;
      unique case (addr)
         ADDR_BURST_CONTROL: begin
            d = s.control[pg] & CONTROL_WRITE_MASK;
            d[RATIO_INVALID_POS] = alarm;
         end
         ADDR_LOW_RES_COUNT_TOP: d = count_byte(s.low_active[pg], 3) & TOP_NIBBLE_MASK;
         ADDR_LOW_RES_COUNT_UPPER: d = count_byte(s.low_active[pg], 2);
         ADDR_LOW_RES_COUNT_MIDDLE: d = count_byte(s.low_active[pg], 1);
         ADDR_LOW_RES_COUNT_BOTTOM: d = count_byte(s.low_active[pg], 0);
         ADDR_HIGH_RES_COUNT_TOP: d = count_byte(s.high_stage[pg], 3) & TOP_NIBBLE_MASK;
         ADDR_HIGH_RES_COUNT_UPPER: d = count_byte(s.high_stage[pg], 2);
         ADDR_HIGH_RES_COUNT_MIDDLE: d = count_byte(s.high_stage[pg], 1);
         ADDR_HIGH_RES_COUNT_BOTTOM: d = count_byte(s.high_stage[pg], 0);
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // Trigger selection and alarm
   // ----------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < PAIR_COUNT; p++) begin
         logic pin_sel;
         logic pin_last;
         pin_sel = 1'b0;
         pin_last = 1'b0;
         if (cur.control[p][TRIGGER_CROSS_POS]) begin
            pin_sel = pin_now[PAIR_COUNT-1-p];
            pin_last = cur.pin_prev[PAIR_COUNT-1-p];
         end else begin
            pin_sel = pin_now[p];
            pin_last = cur.pin_prev[p];
         end
         trigger[p] = cur.control[p][AUTO_TRIGGER_POS] ? 1'b1 : (pin_sel & ~pin_last);
         ratio_invalid[p] = ratio_bad(low_res_count_i[p], cur.high_stage[p]);
      end
   end

   // ----------------------------------------------------------------
   // Burst sequencers, one per pair
   // ----------------------------------------------------------------
   for (genvar g = 0; g < PAIR_COUNT; g++) begin : g_pair
      burst_sequencer #(
         .CW(CW)
      ) u_seq (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .trigger_i(trigger[g]),
         .high_len_i(cur.high_active[g]),
         .low_len_i(cur.low_active[g]),
         .high_res_flag_o(flag[g]),
         .busy_o(busy[g])
      );
   end

   // ----------------------------------------------------------------
   // Register writes, count loading and output bits
   // ----------------------------------------------------------------
   always_comb begin
      logic pg;
      pg = reg_req_i.page;
      next_cur = cur;
      next_cur.pin_prev = pin_now;
      if (reg_req_i.wr) begin
         unique case (reg_req_i.addr)
            ADDR_BURST_CONTROL:
               next_cur.control[pg] = reg_req_i.wdata & CONTROL_WRITE_MASK;
            ADDR_HIGH_RES_COUNT_TOP:
               next_cur.high_stage[pg][27:24] = reg_req_i.wdata[3:0];
            ADDR_HIGH_RES_COUNT_UPPER:
               next_cur.high_stage[pg][23:16] = reg_req_i.wdata;
            ADDR_HIGH_RES_COUNT_MIDDLE:
               next_cur.high_stage[pg][15:8] = reg_req_i.wdata;
            ADDR_HIGH_RES_COUNT_BOTTOM:
               next_cur.high_stage[pg][7:0] = reg_req_i.wdata;
            default: begin
            end
         endcase
      end
      for (int p = 0; p < PAIR_COUNT; p++) begin
         if (cur.control[p][LOAD_COUNTS_POS]) begin
            next_cur.high_active[p] = cur.high_stage[p];
            next_cur.low_active[p] = low_res_count_i[p];
         end
         next_cur.lsb[p][1] = cur.control[p][SECOND_BIT_FLAG_EN_POS] & flag[p];
         next_cur.lsb[p][0] = cur.control[p][FIRST_BIT_FLAG_EN_POS] & flag[p];
      end
      next_cur.rsp.valid = reg_req_i.rd;
      next_cur.rsp.data = reg_req_i.rd ?
         read_mux(cur, pg, reg_req_i.addr, ratio_invalid[pg]) : 8'h00;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign reg_rsp_o = cur.rsp;
   assign res_lsb_o = cur.lsb;
   assign burst_busy_o = busy;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_upper_lsb_gate:
   assert property (!cur.control[0][SECOND_BIT_FLAG_EN_POS] [*2] |-> !res_lsb_o[0][1])
   else $error("Upper LSB not held low while its enable is clear.");

   a_lower_lsb_flag:
   assert property (cur.control[1][FIRST_BIT_FLAG_EN_POS] && flag[1] |=> res_lsb_o[1][0])
   else $error("Lower LSB does not carry the high-resolution flag.");

   a_counts_hold:
   assert property (!cur.control[0][LOAD_COUNTS_POS]
         |=> $stable(cur.high_active[0]) && $stable(cur.low_active[0]))
   else $error("Active counts changed while loading is off.");

   a_counts_load:
   assert property (cur.control[1][LOAD_COUNTS_POS]
         |=> cur.high_active[1] == $past(cur.high_stage[1]))
   else $error("Staged high count not applied while loading is on.");

   a_trigger_cross:
   assert property (!cur.control[0][AUTO_TRIGGER_POS] && cur.control[0][TRIGGER_CROSS_POS]
         && !second_pair_trigger_pin_i |-> !trigger[0])
   else $error("First page triggered without the second pair pin.");

   a_auto_ignores_pin:
   assert property (cur.control[1][AUTO_TRIGGER_POS] && !busy[1] && cur.high_active[1] != '0
         |=> busy[1])
   else $error("Automatic trigger did not start a burst.");

   a_auto_trigger_on:
   assert property (cur.control[0][AUTO_TRIGGER_POS] |-> trigger[0])
   else $error("Automatic trigger not raised on the first page.");

   a_ratio_alarm_read:
   assert property (reg_req_i.rd && reg_req_i.addr == ADDR_BURST_CONTROL && !reg_req_i.page
         |=> reg_rsp_o.valid && reg_rsp_o.data[RATIO_INVALID_POS] == $past(ratio_invalid[0]))
   else $error("Ratio alarm read back wrong.");

   a_ratio_alarm_second:
   assert property (reg_req_i.rd && reg_req_i.addr == ADDR_BURST_CONTROL && reg_req_i.page
         |=> reg_rsp_o.valid && reg_rsp_o.data[RATIO_INVALID_POS] == $past(ratio_invalid[1]))
   else $error("Second page ratio alarm read back wrong.");

   a_control_spare_zero:
   assert property (reg_req_i.rd && reg_req_i.addr == ADDR_BURST_CONTROL
         |=> !reg_rsp_o.data[2] && !reg_rsp_o.data[0])
   else $error("Spare control bits did not read zero.");

   a_upper_lsb_flag:
   assert property (cur.control[1][SECOND_BIT_FLAG_EN_POS] && flag[1] |=> res_lsb_o[1][1])
   else $error("Upper LSB does not carry the high-resolution flag.");

   a_lower_lsb_gate:
   assert property (!cur.control[0][FIRST_BIT_FLAG_EN_POS] |=> !res_lsb_o[0][0])
   else $error("Lower LSB not held low while its enable is clear.");

   a_low_count_load:
   assert property (cur.control[0][LOAD_COUNTS_POS]
         |=> cur.low_active[0] == $past(low_res_count_i[0]))
   else $error("Offered low count not applied while loading is on.");

   a_trigger_own_pin:
   assert property (!cur.control[1][AUTO_TRIGGER_POS] && !cur.control[1][TRIGGER_CROSS_POS]
         && !second_pair_trigger_pin_i |-> !trigger[1])
   else $error("Second page triggered without its own pin.");

   a_low_bottom_read:
   assert property (reg_req_i.rd && reg_req_i.addr == ADDR_LOW_RES_COUNT_BOTTOM && reg_req_i.page
         |=> reg_rsp_o.data == $past(cur.low_active[1][7:0]))
   else $error("Low count bottom byte read wrong.");

   a_idle_response:
   assert property (!reg_req_i.rd |=> !reg_rsp_o.valid && reg_rsp_o.data == 8'h00)
   else $error("Response shown without a read.");

   a_low_top_read:
   assert property (reg_req_i.rd && reg_req_i.addr == ADDR_LOW_RES_COUNT_TOP && !reg_req_i.page
         |=> reg_rsp_o.data == {4'h0, $past(cur.low_active[0][27:24])})
   else $error("Low count top byte read wrong.");

   a_high_bottom_write:
   assert property (reg_req_i.wr && reg_req_i.addr == ADDR_HIGH_RES_COUNT_BOTTOM && reg_req_i.page
         |=> cur.high_stage[1][7:0] == $past(reg_req_i.wdata))
   else $error("High count bottom byte not written.");

   a_high_top_write:
   assert property (reg_req_i.wr && reg_req_i.addr == ADDR_HIGH_RES_COUNT_TOP && !reg_req_i.page
         |=> cur.high_stage[0][27:24] == $past(reg_req_i.wdata[3:0]))
   else $error("High count top nibble not written.");

endmodule

/* trigger_source_model.sv */
`timescale 1ns/1ps
module trigger_source_model
   import burst_resolution_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Pins and counts toward the block
   output logic first_pair_trigger_pin_o,
   output logic second_pair_trigger_pin_o,
   output logic [PAIR_COUNT-1:0][COUNT_WIDTH-1:0] low_res_count_o
);
   initial begin
      first_pair_trigger_pin_o = 1'b0;
      second_pair_trigger_pin_o = 1'b0;
      low_res_count_o = '0;
   end

   // The pin stays high two cycles so the edge is seen as a clean rise.
   task automatic pulse(input logic pin_sel);
      @(negedge clk_i);
      if (pin_sel) begin
         second_pair_trigger_pin_o = 1'b1;
      end else begin
         first_pair_trigger_pin_o = 1'b1;
      end
      repeat (2) @(negedge clk_i);
      first_pair_trigger_pin_o = 1'b0;
      second_pair_trigger_pin_o = 1'b0;
   endtask

   task automatic set_low(input logic pair, input logic [COUNT_WIDTH-1:0] value);
      @(negedge clk_i);
      low_res_count_o[pair] = value;
   endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import burst_resolution_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   reg_req_t req = '0;
   reg_rsp_t rsp;
   logic pin_first;
   logic pin_second;
   logic [PAIR_COUNT-1:0][COUNT_WIDTH-1:0] low_cnt;
   logic [PAIR_COUNT-1:0][1:0] res_lsb;
   logic [PAIR_COUNT-1:0] busy;
   int errors = 0;
   int checks_done = 0;

   always #20 clk_i = ~clk_i;

   burst_resolution_control i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(req),
      .reg_rsp_o(rsp), .first_pair_trigger_pin_i(pin_first),
      .second_pair_trigger_pin_i(pin_second), .low_res_count_i(low_cnt),
      .res_lsb_o(res_lsb), .burst_busy_o(busy));

   trigger_source_model i_partner (.clk_i(clk_i), .first_pair_trigger_pin_o(pin_first),
      .second_pair_trigger_pin_o(pin_second), .low_res_count_o(low_cnt));

   // ----------------------------------------------------------------
   // Compare and bus tasks
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp_reg(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t reg got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_trace(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t trace got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      req = '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: d};
      @(negedge clk_i);
      req = '0;
   endtask

   // The answer stands only in the cycle after the strobe edge, so it is looked at there.
   task automatic rd_chk(input logic pg, input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      req = '{wr: 1'b0, rd: 1'b1, page: pg, addr: a, wdata: 8'h00};
      @(negedge clk_i);
      cmp_reg({rsp.valid, rsp.data}, {1'b1, exp});
      req = '0;
   endtask

   task automatic set_high(input logic pg, input logic [27:0] v);
      reg_wr(pg, ADDR_HIGH_RES_COUNT_TOP, {4'h0, v[27:24]});
      reg_wr(pg, ADDR_HIGH_RES_COUNT_UPPER, v[23:16]);
      reg_wr(pg, ADDR_HIGH_RES_COUNT_MIDDLE, v[15:8]);
      reg_wr(pg, ADDR_HIGH_RES_COUNT_BOTTOM, v[7:0]);
   endtask

   // Bit k of each trace is the state settled after the k-th edge from the pin rise.
   task automatic trace(input int pr, input int pin, output logic [11:0] t1,
                        output logic [11:0] t0, output logic [11:0] tb);
      t1 = '0;
      t0 = '0;
      tb = '0;
      fork
         if (pin >= 0) i_partner.pulse(pin[0]);
         begin
            @(negedge clk_i);
            for (int k = 1; k < 12; k++) begin
               @(negedge clk_i);
               t1[k] = res_lsb[pr][1];
               t0[k] = res_lsb[pr][0];
               tb[k] = busy[pr];
            end
         end
      join
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset_values;
      logic [7:0] addrs [10];
      addrs = '{ADDR_BURST_CONTROL, ADDR_LOW_RES_COUNT_TOP, ADDR_LOW_RES_COUNT_UPPER,
         ADDR_LOW_RES_COUNT_MIDDLE, ADDR_LOW_RES_COUNT_BOTTOM, ADDR_HIGH_RES_COUNT_TOP,
         ADDR_HIGH_RES_COUNT_UPPER, ADDR_HIGH_RES_COUNT_MIDDLE, ADDR_HIGH_RES_COUNT_BOTTOM,
         8'h38};
      for (int p = 0; p < 2; p++) begin
         foreach (addrs[i]) rd_chk(p[0], addrs[i], 8'h00);
      end
      $display("test_reset_values done");
   endtask

   task automatic test_reg_access;
      reg_wr(1'b0, ADDR_BURST_CONTROL, 8'h07);
      rd_chk(1'b0, ADDR_BURST_CONTROL, 8'h00);
      reg_wr(1'b0, ADDR_HIGH_RES_COUNT_TOP, 8'hFF);
      set_high(1'b0, 28'hFA5_5A3C);
      rd_chk(1'b0, ADDR_HIGH_RES_COUNT_TOP, 8'h0F);
      rd_chk(1'b0, ADDR_HIGH_RES_COUNT_UPPER, 8'hA5);
      rd_chk(1'b0, ADDR_HIGH_RES_COUNT_MIDDLE, 8'h5A);
      rd_chk(1'b0, ADDR_HIGH_RES_COUNT_BOTTOM, 8'h3C);
      reg_wr(1'b0, ADDR_LOW_RES_COUNT_UPPER, 8'hFF);
      rd_chk(1'b0, ADDR_LOW_RES_COUNT_UPPER, 8'h00);
      rd_chk(1'b1, ADDR_HIGH_RES_COUNT_BOTTOM, 8'h00);
      rd_chk(1'b0, ADDR_BURST_CONTROL, 8'h02);
      $display("test_reg_access done");
   endtask

   task automatic test_alarm_and_load;
      for (int p = 0; p < 2; p++) begin
         set_high(p[0], 28'h000_0002);
         i_partner.set_low(p[0], 28'h000_0006);
         rd_chk(p[0], ADDR_BURST_CONTROL, 8'h00);
         i_partner.set_low(p[0], 28'h000_0005);
         rd_chk(p[0], ADDR_BURST_CONTROL, 8'h02);
         i_partner.set_low(p[0], 28'h000_0003);
         rd_chk(p[0], ADDR_LOW_RES_COUNT_BOTTOM, 8'h00);
         reg_wr(p[0], ADDR_BURST_CONTROL, 8'h20);
         repeat (2) @(negedge clk_i);
         reg_wr(p[0], ADDR_BURST_CONTROL, 8'h00);
         i_partner.set_low(p[0], 28'h000_0009);
         rd_chk(p[0], ADDR_LOW_RES_COUNT_BOTTOM, 8'h03);
         rd_chk(p[0], ADDR_LOW_RES_COUNT_TOP, 8'h00);
      end
      $display("test_alarm_and_load done");
   endtask

   task automatic test_flags;
      logic [11:0] t1;
      logic [11:0] t0;
      logic [11:0] tb;
      logic [7:0] ctrl [3];
      logic [11:0] e1 [3];
      logic [11:0] e0 [3];
      ctrl = '{8'h80, 8'h40, 8'h00};
      e1 = '{12'h00C, 12'h000, 12'h000};
      e0 = '{12'h000, 12'h00C, 12'h000};
      foreach (ctrl[i]) begin
         reg_wr(1'b0, ADDR_BURST_CONTROL, ctrl[i]);
         trace(0, 0, t1, t0, tb);
         cmp_trace(t1, e1[i]);
         cmp_trace(t0, e0[i]);
         cmp_trace(tb, 12'h03E);
      end
      $display("test_flags done");
   endtask

   task automatic test_cross_and_auto;
      logic [11:0] t1;
      logic [11:0] t0;
      logic [11:0] tb;
      reg_wr(1'b0, ADDR_BURST_CONTROL, 8'h10);
      trace(0, 1, t1, t0, tb);
      cmp_trace(tb, 12'h03E);
      trace(0, 0, t1, t0, tb);
      cmp_trace(tb, 12'h000);
      reg_wr(1'b1, ADDR_BURST_CONTROL, 8'h10);
      trace(1, 0, t1, t0, tb);
      cmp_trace(tb, 12'h03E);
      trace(1, 1, t1, t0, tb);
      cmp_trace(tb, 12'h000);
      // Automatic bursts of two plus three samples repeat with one idle cycle between them.
      reg_wr(1'b1, ADDR_BURST_CONTROL, 8'h08);
      trace(1, -1, t1, t0, tb);
      cmp_trace(tb, 12'h7DE);
      $display("test_cross_and_auto done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(negedge clk_i);
      rst_b_i = 1'b1;
      test_reset_values();
      test_reg_access();
      test_alarm_and_load();
      test_flags();
      test_cross_and_auto();
      stop_test();
   end

   // About 250 cycles are needed; the margin covers slow bursts.
   initial begin
      repeat (6000) @(posedge clk_i);
      errors++;
      stop_test();
   end
endmodule
